// [shared/rcx_pkg.sv]
// Package of offsets, field layouts, reset values and timing for the ROM control register block.
package rcx_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CORE_CONTROL = 12'h13c;
    localparam logic [11:0] OFF_PCI_ADDR_EXT = 12'h140;
    localparam logic [11:0] OFF_DAC_ADDR_LO = 12'h200;
    localparam logic [11:0] OFF_DAC_ADDR_HI = 12'h204;
    localparam logic [11:0] OFF_ADDR31_ALIAS = 12'h20c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int I2O_SIZE_LSB = 10;
    localparam int WDOG_BIT = 13;
    localparam int ROM_WIDTH_LSB = 14;
    localparam int ROM_ACCESS_LSB = 16;
    localparam int ROM_BURST_LSB = 20;
    localparam int ROM_TRI_LSB = 24;
    localparam int XCS_DIR_LSB = 28;
    localparam int CFN_BIT = 31;
    localparam int EXT_A31_BIT = 15;
    localparam int EXT_IO_LSB = 16;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] I2O_SIZE_RST = 3'h0;
    localparam logic WDOG_RST = 1'b0;
    localparam logic [1:0] ROM_W_RST = 2'h0;
    localparam logic EXT_A31_RST = 1'b0;
    localparam logic [3:0] ROM_TIME_RST = 4'h0;
    localparam logic [2:0] XCS_DIR_RST = 3'h0;
    localparam logic [3:0] ZERO_CODE_CYCLES = 4'h0;
    localparam logic [4:0] LONG_COUNT = 5'h10;
    localparam logic [1:0] ROM_W_BYTE = 2'h3;
    localparam logic [1:0] ROM_W_WORD = 2'h1;
    localparam logic [1:0] ROM_W_DWORD = 2'h2;
    localparam logic [15:0] EXT_IO_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } rcx_req_t;

    typedef struct packed {
        logic [4:0] access_cycles;
        logic [4:0] burst_cycles;
        logic [4:0] tristate_cycles;
        logic [1:0] rom_width;
    } rcx_rom_timing_t;

    typedef struct packed {
        logic [16:0] inc_mask;
        logic [16:0] entries_m1;
    } rcx_i2o_t;

endpackage

// [verilog/rcx_time_decode.sv]
// Decoder of a four-bit ROM timing code into a count of core clock cycles.
`timescale 1ns/1ps
`default_nettype none

module rcx_time_decode (
    input wire logic [3:0] code,
    output logic [4:0] cycles
);

    // Code zero stands for the long count of sixteen cycles.
    always_comb begin
        if (code == rcx_pkg::ZERO_CODE_CYCLES) begin
            cycles = rcx_pkg::LONG_COUNT;
        end else begin
            cycles = {1'b0, code};
        end
    end

endmodule // rcx_time_decode

`default_nettype wire

// [verilog/rcx_i2o_decode.sv]
// Decoder of the I2O list size code into the pointer count mask and entry count.
`timescale 1ns/1ps
`default_nettype none

module rcx_i2o_decode (
    input wire logic [2:0] size_code,
    output rcx_pkg::rcx_i2o_t i2o
);

    logic [17:0] span;

    // Code 0 counts pointer bits 9:2; each step adds one bit and doubles the list.
    always_comb begin
        span = 18'h00400 << size_code;
        i2o.inc_mask = 17'(span - 18'h00004);
        i2o.entries_m1 = 17'((span >> 2) - 18'h00001);
    end

endmodule // rcx_i2o_decode

`default_nettype wire

// [verilog/rcx_regs.sv]
// Core control upper fields and PCI address extension register logic.
//
// Operation
// - The watchdog enable bit 13 is set by writing one, cleared only by reset, and while set a timer 4 zero resets the host.
// - ROM width bits 15:14 read the value latched from the two strap lines: 11 byte, 01 word, 10 dword.
// - ROM access time bits 19:16 give first-access cycles, 0 meaning 16, reset 0.
// - ROM burst time bits 23:20 give later-access cycles, 0 meaning 16, with 1 and 2 illegal.
// - ROM tristate time bits 27:24 give bus turnaround cycles, 1 illegal, 0 the long count, reset 0.
// - Bits 30:28 set each chip-select line direction while the arbiter is not internal, 1 output, reset 0.
// - Bit 31 reads the present level of the central-function strap pin.
// - The list size code picks 256 entries counting bits 9:2, doubling per code up to 32K with bits 16:2.
// - List size bits 12:10 choose which head and tail pointer bits count, reset 0.
// - Extension bit 15 drives PCI address bit 31 on host memory cycles, single or dual address.
// - A write to the extension register loads bit 15 from write data bit 15.
// - Any write to offset 200h clears extension bit 15 and any write to 204h sets it.
// - Extension bit 15 also reads at the alias offset 20Ch.
// - Extension bits 31:16 drive PCI address 31:16 on host I/O cycles; bits 14:0 read zero.
`timescale 1ns/1ps
`default_nettype none

module rcx_regs (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire rcx_pkg::rcx_req_t req,
    output logic [31:0] rdata,
    output logic rd_hit,
    input wire logic [1:0] mem_addr_strap_bits,
    input wire logic pci_cfn,
    input wire logic timer4_zero,
    input wire logic arbiter_internal,
    input wire logic [2:0] xcs_in,
    input wire logic [2:0] xcs_core_out,
    output logic [2:0] xcs_out,
    output logic [2:0] xcs_oe,
    output logic [2:0] xcs_to_core,
    output logic host_wdog_reset,
    input wire logic pci_mem_cycle,
    input wire logic pci_io_cycle,
    input wire logic [31:0] pci_addr_in,
    output logic [31:0] pci_addr_out,
    output rcx_pkg::rcx_rom_timing_t rom_timing,
    output rcx_pkg::rcx_i2o_t i2o_ctl,
    output logic [2:0] i2o_list_size
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic wdog_en;
    logic [1:0] rom_width;
    logic strap_taken;
    logic [3:0] rom_access;
    logic [3:0] rom_burst;
    logic [3:0] rom_tri;
    logic [2:0] xcs_dir;
    logic ext_a31;
    logic [15:0] ext_io;
    logic wr_ctl;
    logic wr_ext;
    logic wr_dac_lo;
    logic wr_dac_hi;
    logic [31:0] ctl_word;
    logic [31:0] ext_word;
    logic [31:0] next_rdata;
    logic next_hit;

    assign wr_ctl = req.wr && (req.addr == rcx_pkg::OFF_CORE_CONTROL);
    assign wr_ext = req.wr && (req.addr == rcx_pkg::OFF_PCI_ADDR_EXT);
    assign wr_dac_lo = req.wr && (req.addr == rcx_pkg::OFF_DAC_ADDR_LO);
    assign wr_dac_hi = req.wr && (req.addr == rcx_pkg::OFF_DAC_ADDR_HI);

    // ------------------------------------------------------------------
    // Watchdog enable
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdog_en <= rcx_pkg::WDOG_RST;
        end else if (wr_ctl && req.wdata[rcx_pkg::WDOG_BIT]) begin
            wdog_en <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Host reset request
    // ------------------------------------------------------------------
    // Timer 4 at zero resets the host only while the watchdog is armed.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_wdog_reset <= 1'b0;
        end else begin
            host_wdog_reset <= wdog_en && timer4_zero;
        end
    end

    // ------------------------------------------------------------------
    // ROM width strap capture
    // ------------------------------------------------------------------
    // The strap is caught on the first clock after reset release.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_taken <= 1'b0;
            rom_width <= rcx_pkg::ROM_W_RST;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            rom_width <= mem_addr_strap_bits;
        end
    end

    // ------------------------------------------------------------------
    // ROM timing fields
    // ------------------------------------------------------------------
    // Illegal codes are stored as written; software keeps them out.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rom_access <= rcx_pkg::ROM_TIME_RST;
        end else if (wr_ctl) begin
            rom_access <= req.wdata[rcx_pkg::ROM_ACCESS_LSB +: 4];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rom_burst <= rcx_pkg::ROM_TIME_RST;
        end else if (wr_ctl) begin
            rom_burst <= req.wdata[rcx_pkg::ROM_BURST_LSB +: 4];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rom_tri <= rcx_pkg::ROM_TIME_RST;
        end else if (wr_ctl) begin
            rom_tri <= req.wdata[rcx_pkg::ROM_TRI_LSB +: 4];
        end
    end

    rcx_time_decode u_access (
        .code(rom_access),
        .cycles(rom_timing.access_cycles)
    );

    rcx_time_decode u_burst (
        .code(rom_burst),
        .cycles(rom_timing.burst_cycles)
    );

    rcx_time_decode u_tri (
        .code(rom_tri),
        .cycles(rom_timing.tristate_cycles)
    );

    assign rom_timing.rom_width = rom_width;

    // ------------------------------------------------------------------
    // Chip-select direction
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            xcs_dir <= rcx_pkg::XCS_DIR_RST;
        end else if (wr_ctl) begin
            xcs_dir <= req.wdata[rcx_pkg::XCS_DIR_LSB +: 3];
        end
    end

    // The arbiter owns the lines when selected, so the direction bits are ignored then.
    always_comb begin
        xcs_oe = arbiter_internal ? 3'h0 : xcs_dir;
    end

    // ------------------------------------------------------------------
    // Chip-select pin routing
    // ------------------------------------------------------------------
    assign xcs_out = xcs_core_out;
    assign xcs_to_core = xcs_in;

    // ------------------------------------------------------------------
    // I2O list size
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            i2o_list_size <= rcx_pkg::I2O_SIZE_RST;
        end else if (wr_ctl) begin
            i2o_list_size <= req.wdata[rcx_pkg::I2O_SIZE_LSB +: 3];
        end
    end

    rcx_i2o_decode u_i2o (
        .size_code(i2o_list_size),
        .i2o(i2o_ctl)
    );

    // ------------------------------------------------------------------
    // PCI address extension
    // ------------------------------------------------------------------
    // No reset value is defined for these bits; zero is chosen for determinism.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_a31 <= rcx_pkg::EXT_A31_RST;
        end else if (wr_ext) begin
            ext_a31 <= req.wdata[rcx_pkg::EXT_A31_BIT];
        end else if (wr_dac_lo) begin
            ext_a31 <= 1'b0;
        end else if (wr_dac_hi) begin
            ext_a31 <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // I/O space upper address field
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_io <= rcx_pkg::EXT_IO_RST;
        end else if (wr_ext) begin
            ext_io <= req.wdata[rcx_pkg::EXT_IO_LSB +: 16];
        end
    end

    // ------------------------------------------------------------------
    // PCI address substitution
    // ------------------------------------------------------------------
    // An I/O cycle wins over a memory cycle when both qualifiers are high.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pci_addr_out <= 32'h00000000;
        end else if (pci_io_cycle) begin
            pci_addr_out <= {ext_io, pci_addr_in[15:0]};
        end else if (pci_mem_cycle) begin
            pci_addr_out <= {ext_a31, pci_addr_in[30:0]};
        end else begin
            pci_addr_out <= pci_addr_in;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        ctl_word = 32'h00000000;
        ctl_word[rcx_pkg::I2O_SIZE_LSB +: 3] = i2o_list_size;
        ctl_word[rcx_pkg::WDOG_BIT] = wdog_en;
        ctl_word[rcx_pkg::ROM_WIDTH_LSB +: 2] = rom_width;
        ctl_word[rcx_pkg::ROM_ACCESS_LSB +: 4] = rom_access;
        ctl_word[rcx_pkg::ROM_BURST_LSB +: 4] = rom_burst;
        ctl_word[rcx_pkg::ROM_TRI_LSB +: 4] = rom_tri;
        ctl_word[rcx_pkg::XCS_DIR_LSB +: 3] = xcs_dir;
        ctl_word[rcx_pkg::CFN_BIT] = pci_cfn;
    end

    always_comb begin
        ext_word = 32'h00000000;
        ext_word[rcx_pkg::EXT_A31_BIT] = ext_a31;
        ext_word[rcx_pkg::EXT_IO_LSB +: 16] = ext_io;
    end

    // ------------------------------------------------------------------
    // Read select
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h00000000;
        next_hit = 1'b0;
        case (req.addr)
            rcx_pkg::OFF_CORE_CONTROL: begin
                next_rdata = ctl_word;
                next_hit = req.rd;
            end
            rcx_pkg::OFF_PCI_ADDR_EXT: begin
                next_rdata = ext_word;
                next_hit = req.rd;
            end
            rcx_pkg::OFF_ADDR31_ALIAS: begin
                next_rdata[rcx_pkg::EXT_A31_BIT] = ext_a31;
                next_hit = req.rd;
            end
            default: begin
                next_rdata = 32'h00000000;
                next_hit = 1'b0;
            end
        endcase
        if (!req.rd) begin
            next_rdata = 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Registered answer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_hit <= 1'b0;
        end else begin
            rd_hit <= next_hit;
        end
    end

endmodule // rcx_regs

`default_nettype wire

// [sim/rcx_regs_assertions.sv]
// Checker of the ROM control and PCI address extension register block.
`timescale 1ns/1ps
`default_nettype none

module rcx_regs_assertions (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire rcx_pkg::rcx_req_t req,
    input wire logic [31:0] rdata,
    input wire logic rd_hit,
    input wire logic pci_cfn,
    input wire logic timer4_zero,
    input wire logic arbiter_internal,
    input wire logic [2:0] xcs_oe,
    input wire logic host_wdog_reset,
    input wire logic pci_mem_cycle,
    input wire logic pci_io_cycle,
    input wire logic [31:0] pci_addr_in,
    input wire logic [31:0] pci_addr_out,
    input wire rcx_pkg::rcx_rom_timing_t rom_timing
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic wr_ctl, rd_ctl, mem_only;
    assign wr_ctl = req.wr && req.addr == rcx_pkg::OFF_CORE_CONTROL;
    assign rd_ctl = req.rd && req.addr == rcx_pkg::OFF_CORE_CONTROL;
    assign mem_only = pci_mem_cycle && !pci_io_cycle;

    a_wdog_on: assert property (wr_ctl && req.wdata[13] && timer4_zero
        ##1 timer4_zero |=> host_wdog_reset) else $error("watchdog reset missing");
    a_wdog_off: assert property (!timer4_zero |=> !host_wdog_reset)
        else $error("watchdog reset without timer");
    a_cfn_live: assert property (rd_ctl |=> rdata[31] == $past(pci_cfn))
        else $error("strap bit wrong");
    a_acc_decode: assert property (wr_ctl |=> rom_timing.access_cycles ==
        ($past(req.wdata[19:16]) == 4'h0 ? 5'h10 : {1'b0, $past(req.wdata[19:16])}))
        else $error("access count wrong");
    a_xcs_dir: assert property (wr_ctl ##1 !arbiter_internal |->
        xcs_oe == $past(req.wdata[30:28])) else $error("direction wrong");
    a_ext_zero: assert property (req.rd && req.addr == 12'h140 |=>
        rd_hit && rdata[14:0] == 15'h0) else $error("extension low bits set");
    a_alias_read: assert property (req.rd && req.addr == 12'h20c |=>
        rd_hit && rdata[31:16] == 16'h0 && rdata[14:0] == 15'h0) else $error("alias wrong");
    a_dac_clear: assert property (req.wr && req.addr == 12'h200 ##1 mem_only |=>
        !pci_addr_out[31]) else $error("address bit not cleared");
    a_dac_set: assert property (req.wr && req.addr == 12'h204 ##1 mem_only |=>
        pci_addr_out == {1'b1, $past(pci_addr_in[30:0])}) else $error("address bit not set");
    a_io_low: assert property (pci_io_cycle |=>
        pci_addr_out[15:0] == $past(pci_addr_in[15:0])) else $error("io low half wrong");

    c_wdog: cover property (host_wdog_reset);
    c_dac_set: cover property (req.wr && req.addr == 12'h204 ##1 mem_only);
    c_io_mem: cover property (pci_io_cycle && pci_mem_cycle);
endmodule // rcx_regs_assertions

bind rcx_regs rcx_regs_assertions u_chk (.sys_clk, .sys_rst, .req, .rdata, .rd_hit,
    .pci_cfn, .timer4_zero, .arbiter_internal, .xcs_oe, .host_wdog_reset, .pci_mem_cycle,
    .pci_io_cycle, .pci_addr_in, .pci_addr_out, .rom_timing);

`default_nettype wire

// [sim/rcx_host_model.sv]
// Host processor model that issues register reads and writes.
`timescale 1ns/1ps
`default_nettype none

module rcx_host_model (
    input wire logic sys_clk,
    input wire logic [31:0] rdata,
    input wire logic rd_hit,
    output var rcx_pkg::rcx_req_t req
);
    initial req = '0;

    // Holds a request across one rising edge, then leaves an inverted idle pattern.
    task automatic issue(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(negedge sys_clk);
        req <= '{wr: w, rd: ~w, addr: a, wdata: v};
        @(negedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask

    task automatic write(input logic [11:0] a, input logic [31:0] v);
        issue(1'b1, a, v);
    endtask

    task automatic read(input logic [11:0] a, output logic [31:0] v, output logic h);
        issue(1'b0, a, 32'h0);
        v = rdata;
        h = rd_hit;
    endtask
endmodule // rcx_host_model

`default_nettype wire

// [sim/tb_rcx_regs_and_pci_addr_ext.sv]
// Testbench of the ROM control and PCI address extension register block.
`timescale 1ns/1ps
`default_nettype none

module tb_rom_ctrl_and_pci_addr_ext_regs;
    localparam logic [11:0] CTL = rcx_pkg::OFF_CORE_CONTROL;
    logic sys_clk = 1'b0, sys_rst = 1'b1, pci_cfn = 1'b0, timer4_zero = 1'b0;
    logic arbiter_internal = 1'b0, pci_mem_cycle = 1'b0, pci_io_cycle = 1'b0;
    logic [1:0] mem_addr_strap_bits = 2'h0;
    logic [2:0] xcs_in = 3'h0, xcs_core_out = 3'h0;
    logic [31:0] pci_addr_in = 32'h0;
    logic rd_hit, host_wdog_reset;
    logic [2:0] xcs_out, xcs_oe, xcs_to_core, i2o_list_size;
    logic [31:0] rdata, pci_addr_out, d;
    logic [3:0] t;
    rcx_pkg::rcx_req_t req;
    rcx_pkg::rcx_rom_timing_t rom_timing;
    rcx_pkg::rcx_i2o_t i2o_ctl;
    int num_errors = 0;
    int checks = 0;

    rcx_regs dut (.sys_clk, .sys_rst, .req, .rdata, .rd_hit, .mem_addr_strap_bits, .pci_cfn,
        .timer4_zero, .arbiter_internal, .xcs_in, .xcs_core_out, .xcs_out, .xcs_oe,
        .xcs_to_core, .host_wdog_reset, .pci_mem_cycle, .pci_io_cycle, .pci_addr_in,
        .pci_addr_out, .rom_timing, .i2o_ctl, .i2o_list_size);
    rcx_host_model host (.sys_clk, .rdata, .rd_hit, .req);

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic h;
        host.read(a, v, h);
        chk("rdata", e, v & m);
        chk("rd_hit", 32'(a != 12'h144), 32'(h));
    endtask

    task automatic pchk(input logic m, input logic io, input logic [31:0] a, input logic [31:0] e);
        pci_mem_cycle = m;
        pci_io_cycle = io;
        pci_addr_in = a;
        @(negedge sys_clk);
        chk("pci_addr_out", e, pci_addr_out);
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic endt(input string n);
        $display("test %s finished", n);
    endtask

    function automatic logic [31:0] dec(input logic [3:0] c);
        return (c == 4'h0) ? 32'h10 : 32'(c);
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        for (int s = 0; s < 4; s++) begin
            mem_addr_strap_bits = 2'(s);
            pci_cfn = s[0];
            do_reset();
            rchk(CTL, ~32'h3ff, {s[0], 15'h0, 2'(s), 14'h0});
            chk("rom_width", 32'(s), 32'(rom_timing.rom_width));
            chk("access", 32'h10, 32'(rom_timing.access_cycles));
            chk("burst", 32'h10, 32'(rom_timing.burst_cycles));
            chk("tristate", 32'h10, 32'(rom_timing.tristate_cycles));
            chk("xcs_oe", 32'h0, 32'(xcs_oe));
            chk("list_size", 32'h0, 32'(i2o_list_size));
        end
        endt("reset");
        for (int c = 0; c < 8; c++) begin
            t = (c == 0) ? 4'h0 : 4'(c + 2);
            d = {1'b0, 3'(c), 4'(2 * c), t, t, 3'h0, 3'(c), 10'h0};
            host.write(CTL, d);
            chk("access", dec(t), 32'(rom_timing.access_cycles));
            chk("burst", dec(t), 32'(rom_timing.burst_cycles));
            chk("tristate", dec(4'(2 * c)), 32'(rom_timing.tristate_cycles));
            chk("xcs_oe", 32'(c), 32'(xcs_oe));
            chk("inc_mask", 32'(((1 << (c + 8)) - 1) << 2), 32'(i2o_ctl.inc_mask));
            chk("entries", 32'((256 << c) - 1), 32'(i2o_ctl.entries_m1));
            chk("list_size", 32'(c), 32'(i2o_list_size));
            rchk(CTL, ~32'h3ff, d | 32'h8000c000);
        end
        endt("fields");
        arbiter_internal = 1'b1;
        xcs_core_out = 3'h5;
        xcs_in = 3'h2;
        @(negedge sys_clk);
        chk("xcs_oe", 32'h0, 32'(xcs_oe));
        chk("xcs_out", 32'h5, 32'(xcs_out));
        chk("xcs_to_core", 32'h2, 32'(xcs_to_core));
        arbiter_internal = 1'b0;
        endt("xcs");
        timer4_zero = 1'b1;
        host.write(CTL, 32'h0);
        @(negedge sys_clk);
        chk("wdog_reset", 32'h0, 32'(host_wdog_reset));
        host.write(CTL, 32'h2000);
        @(negedge sys_clk);
        chk("wdog_reset", 32'h1, 32'(host_wdog_reset));
        host.write(CTL, 32'h0);
        rchk(CTL, 32'h2000, 32'h2000);
        timer4_zero = 1'b0;
        @(negedge sys_clk);
        chk("wdog_reset", 32'h0, 32'(host_wdog_reset));
        do_reset();
        rchk(CTL, 32'h2000, 32'h0);
        endt("watchdog");
        host.write(12'h140, 32'habcdffff);
        rchk(12'h140, '1, 32'habcd8000);
        rchk(12'h20c, '1, 32'h8000);
        host.write(12'h200, 32'hffffffff);
        pchk(1'b1, 1'b0, 32'hffffffff, 32'h7fffffff);
        host.write(12'h204, 32'h0);
        pchk(1'b1, 1'b0, 32'h0, 32'h80000000);
        pchk(1'b0, 1'b1, 32'hffffffff, 32'habcdffff);
        pchk(1'b1, 1'b1, 32'h0, 32'habcd0000);
        pchk(1'b0, 1'b0, 32'h12345678, 32'h12345678);
        host.write(12'h20c, 32'h0);
        rchk(12'h20c, '1, 32'h8000);
        host.write(12'h140, 32'h12340000);
        rchk(12'h140, '1, 32'h12340000);
        rchk(12'h20c, '1, 32'h0);
        rchk(12'h144, '1, 32'h0);
        endt("extension");
        final_report();
    end
endmodule // tb_rom_ctrl_and_pci_addr_ext_regs

`default_nettype wire
